// [rtl/qia_pkg.sv]
// constants, carriers and helpers for the quad uart interrupt arbiter
//
// Overview of operation
// - global registers are views chosen by capture
// - views: fill count, channel, type, both queues
// - global receive view reads context channel queue
// - gang write and gang load commands
// - gang load sets resume 11, pause 13
// - flow recognition uses current character registers
// - address marked by parity bit or value
// - own address wakes receiver, pushes data
// - optional doze on foreign address
// - control characters stripped or pushed per mode
// - actions happen whether stripped or not
// - recognition events set status bits
// - only masked-in sources bid against threshold
// - bid holds channel, type, fill, programmed field
// - request low only while bid beats threshold
// - acknowledge or update command captures winner
// - capture shows channel, type, fill, error
// - capture steers global views and vector
// - ten-bit scan, result every 22 clocks
// - bid changes wait for next arbitration
// - programmed high bits rank other sources
// - rx bid grows with fill, tx with room
// - threshold bits 6:0 meet bid 9:3
// - capture with no winner loads zero
// - channel number breaks ties, d highest
package qia_pkg;
	localparam int QIA_NCH     = 4;  // uart channels
	localparam int QIA_NSRC    = 6;  // sources per channel
	localparam int QIA_DEPTH   = 16; // queue depth
	localparam int QIA_BID_W   = 10; // arbitration bus width
	localparam int QIA_ARB_LEN = 22; // clocks per arbitration
	// word offsets, global block
	localparam logic [5:0] QIA_OFS_CTRL = 6'h00; // irq_control_reg
	localparam logic [5:0] QIA_OFS_MASK = 6'h01; // irq_source_mask
	localparam logic [5:0] QIA_OFS_CAPT = 6'h02; // irq_capture_reg
	localparam logic [5:0] QIA_OFS_VBAS = 6'h03; // vector base
	localparam logic [5:0] QIA_OFS_CMD  = 6'h04; // command register, gang and update
	localparam logic [5:0] QIA_OFS_GCNT = 6'h05; // global_fifo_count_view
	localparam logic [5:0] QIA_OFS_GCHN = 6'h06; // global_channel_view
	localparam logic [5:0] QIA_OFS_GTYP = 6'h07; // global_type_view
	localparam logic [5:0] QIA_OFS_GRX  = 6'h08; // global_receive_fifo_view
	localparam logic [5:0] QIA_OFS_GTX  = 6'h09; // global_transmit_fifo_view
	// channel block at 0x10 + 4*ch
	localparam logic [1:0] QIA_CH_BLK   = 2'h1;
	localparam logic [1:0] QIA_SUB_MODE = 2'h0; // mode_reg_zero
	localparam logic [1:0] QIA_SUB_CHR  = 2'h1; // resume, pause, own address
	localparam logic [1:0] QIA_SUB_DATA = 2'h2; // direct queue data
	localparam logic [1:0] QIA_SUB_STAT = 2'h3; // irq_status_reg, extended_irq_status
	// commands
	localparam logic [7:0] QIA_CMD_GWRITE = 8'h01;
	localparam logic [7:0] QIA_CMD_GLOAD  = 8'h02;
	localparam logic [7:0] QIA_CMD_UPDATE = 8'h03;
	localparam logic [7:0] QIA_XON_STD    = 8'h11;
	localparam logic [7:0] QIA_XOFF_STD   = 8'h13;
	// reset values
	localparam logic [7:0]  QIA_RST_CTRL = 8'h00;
	localparam logic [23:0] QIA_RST_MASK = 24'h000000;
	localparam logic [7:0]  QIA_RST_VBAS = 8'h0f;
	localparam logic [7:0]  QIA_RST_MODE = 8'h00;
	// source index inside a channel
	localparam int QIA_SRC_RX = 0, QIA_SRC_TX = 1, QIA_SRC_BRK = 2;
	localparam int QIA_SRC_COS = 3, QIA_SRC_FLOW = 4, QIA_SRC_ADDR = 5;
	// sticky status positions
	localparam int QIA_ST_BRK = 0, QIA_ST_COS = 1, QIA_ST_XON = 2;
	localparam int QIA_ST_XOFF = 3, QIA_ST_ADDR = 4;
	// bid type codes in bits 5:3
	localparam logic [2:0] QIA_TY_BRK  = 3'h2;
	localparam logic [2:0] QIA_TY_COS  = 3'h6;
	localparam logic [2:0] QIA_TY_FLOW = 3'h7;
	localparam logic [2:0] QIA_TY_ADDR = 3'h3;
	localparam logic [2:0] QIA_TY_RX   = 3'h1; // view code, good data
	localparam logic [2:0] QIA_TY_RXE  = 3'h5; // view code, error data
	localparam logic [2:0] QIA_TY_TX   = 3'h0;

	typedef struct packed {
		logic [2:0] prog;      // programmed bid field
		logic       par_addr;  // address marked by parity bit
		logic       strip;     // discard control characters
		logic       doze_en;   // sleep on foreign address
		logic       multidrop; // wake-up mode
		logic       flow_en;   // in-band flow control
	} qia_mode_type;

	typedef struct packed {
		logic [3:0]       rx_valid;    // character received
		logic [3:0][7:0]  rx_data;
		logic [3:0]       rx_addr_bit; // parity position
		logic [3:0]       rx_err;
		logic [3:0]       brk_chg;     // change of break event
		logic [3:0]       cos;         // change of state event
		logic [3:0]       tx_take;     // line took tx_data
	} qia_line_in_type;

	typedef struct packed {
		logic [3:0]      tx_valid;
		logic [3:0][7:0] tx_data;
		logic [3:0]      tx_paused;  // halted by pause character
		logic [3:0]      rx_enabled;
	} qia_line_out_type;

	// type view code from a captured bid
	function automatic logic [2:0] qia_type_of(input logic [9:0] b);
		if (b[4:3] == 2'b01)
			return b[5] ? QIA_TY_RXE : QIA_TY_RX;
		else if (b[4:3] == 2'b00)
			return QIA_TY_TX;
		return b[5:3];
	endfunction
endpackage

// [rtl/qia_chan_recog.sv]
// per-channel character recognition: flow control, wake and doze, stripping
`timescale 1ns/1ps
`default_nettype none
module qia_chan_recog
	import qia_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         resetn_i,
	input  wire qia_mode_type mode_i,
	input  wire logic [7:0]   xon_i,
	input  wire logic [7:0]   xoff_i,
	input  wire logic [7:0]   own_i,
	input  wire logic         rx_valid_i,
	input  wire logic [7:0]   rx_data_i,
	input  wire logic         rx_addr_bit_i,
	output logic              push_o,
	output logic              xon_hit_o,
	output logic              xoff_hit_o,
	output logic              addr_hit_o,
	output logic              enabled_o,
	output logic              paused_o
);
	typedef struct packed {
		logic awake;  // woken by own address
		logic paused; // transmitter held by pause character
	} qia_rec_state_type;

	qia_rec_state_type s, next_s;
	logic is_addr, own, other, ctl; // decode of the current character

	// decode and next state
	always_comb begin
		next_s = s;
		is_addr = mode_i.multidrop &&
			(mode_i.par_addr ? rx_addr_bit_i : (rx_data_i == own_i));
		own = rx_valid_i && is_addr && (rx_data_i == own_i);
		other = rx_valid_i && is_addr && (rx_data_i != own_i);
		xon_hit_o = rx_valid_i && mode_i.flow_en && !is_addr && (rx_data_i == xon_i);
		xoff_hit_o = rx_valid_i && mode_i.flow_en && !is_addr && (rx_data_i == xoff_i);
		addr_hit_o = own;
		enabled_o = !mode_i.multidrop || s.awake;
		ctl = xon_hit_o || xoff_hit_o || own;
		// stripped characters still act below; foreign addresses never enter
		push_o = rx_valid_i && (enabled_o || own) && !other && !(mode_i.strip && ctl);
		if (!mode_i.multidrop) begin
			next_s.awake = 1'b0;
		end else if (own) begin
			next_s.awake = 1'b1;
		end else if (other && mode_i.doze_en) begin
			next_s.awake = 1'b0;
		end
		if (!mode_i.flow_en) begin
			next_s.paused = 1'b0;
		end else if (xoff_hit_o) begin
			next_s.paused = 1'b1;
		end else if (xon_hit_o) begin
			next_s.paused = 1'b0;
		end
		paused_o = s.paused;
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			s <= '0;
		else
			s <= next_s;
	end
endmodule
`default_nettype wire

// [rtl/qia_arbiter.sv]
// interrupt arbiter, capture, global views, queues and avalon slave
`timescale 1ns/1ps
`default_nettype none
module qia_arbiter
	import qia_pkg::*;
#(
	parameter int NCH   = QIA_NCH,
	parameter int DEPTH = QIA_DEPTH
) (
	input  wire logic             sys_clk_i,
	input  wire logic             resetn_i,
	input  wire logic [5:0]       avs_address_i,
	input  wire logic             avs_read_i,
	input  wire logic             avs_write_i,
	input  wire logic [31:0]      avs_writedata_i,
	output logic [31:0]           avs_readdata_o,
	output logic                  avs_waitrequest_o,
	input  wire logic             irq_acknowledge_n_i,
	output logic                  irq_request_n_o,
	output logic [7:0]            irq_vector_o,
	input  wire qia_line_in_type  line_i,
	output qia_line_out_type      line_o
);
	localparam int NS = NCH * QIA_NSRC; // total sources

	typedef struct packed {
		logic                          waitrq;   // avalon waitrequest
		logic [31:0]                   rdata;
		logic                          peek_ok;  // read saw a queued char
		logic [7:0]                    ctrl;     // threshold 6:0, vector mod 7
		logic [23:0]                   mask;
		logic [7:0]                    vbase;
		logic [9:0]                    capt;     // irq_capture_reg
		logic [7:0]                    vec;
		logic                          irq_n;
		logic                          ack_d;    // acknowledge last cycle
		logic [3:0][7:0]               mode;
		logic [3:0][7:0]               xon;
		logic [3:0][7:0]               xoff;
		logic [3:0][7:0]               own;
		logic [3:0][4:0]               sticky;   // latched line and recognition events
		logic [3:0][15:0][8:0]         rxm;      // receive_queue, err in bit 8
		logic [3:0][3:0]               rx_rd;
		logic [3:0][3:0]               rx_wr;
		logic [3:0][4:0]               rx_cnt;
		logic [3:0][15:0][7:0]         txm;      // transmit_queue
		logic [3:0][3:0]               tx_rd;
		logic [3:0][3:0]               tx_wr;
		logic [3:0][4:0]               tx_cnt;
		logic [4:0]                    arb_cnt;
		logic [23:0][9:0]              snap;     // bids frozen per arbitration
		logic [23:0]                   cand;     // sources still in the race
		logic [9:0]                    res_bid;
		logic                          res_ok;   // result beats threshold
		qia_line_out_type              line;
	} qia_top_state_type;

	qia_top_state_type s, n;

	logic [3:0] push_w, xon_w, xoff_w, addr_w, en_w, pause_w; // recognition outputs

	// one recogniser per channel
	for (genvar c = 0; c < NCH; c++) begin : g_rec
		qia_chan_recog u_rec (
			.sys_clk_i     (sys_clk_i),
			.resetn_i      (resetn_i),
			.mode_i        (qia_mode_type'(s.mode[c])),
			.xon_i         (s.xon[c]),
			.xoff_i        (s.xoff[c]),
			.own_i         (s.own[c]),
			.rx_valid_i    (line_i.rx_valid[c]),
			.rx_data_i     (line_i.rx_data[c]),
			.rx_addr_bit_i (line_i.rx_addr_bit[c]),
			.push_o        (push_w[c]),
			.xon_hit_o     (xon_w[c]),
			.xoff_hit_o    (xoff_w[c]),
			.addr_hit_o    (addr_w[c]),
			.enabled_o     (en_w[c]),
			.paused_o      (pause_w[c])
		);
	end

	// all next-state logic
	always_comb begin
		logic [23:0][9:0] bid;    // live bids
		logic [23:0]      act;    // live active sources
		logic [23:0]      col;    // scanned bit of each candidate
		logic [9:0]       win;
		logic             req, go, cap, rd, wr;
		logic [1:0]       gch;    // context channel
		logic [1:0]       ch;
		logic [3:0]       rx_pop, tx_push;
		logic [7:0]       tx_byte;
		logic [4:0]       clr;
		logic [4:0]       set;
		logic [31:0]      rv;
		qia_mode_type     md;
		n = s;
		bid = '0;
		act = '0;
		col = '0;
		win = '0;
		rx_pop = '0;
		tx_push = '0;
		tx_byte = avs_writedata_i[7:0];
		cap = 1'b0;
		rv = '0;
		clr = '0;
		set = '0;
		md = '0;
		ch = avs_address_i[3:2];
		gch = s.capt[1:0];
		req = avs_read_i || avs_write_i;
		go = req && !s.waitrq; // the edge where the access completes
		rd = go && avs_read_i;
		wr = go && avs_write_i;
		// one wait state, then the answer stands for one cycle
		n.waitrq = !(req && s.waitrq);

		// bids of every source
		for (int c = 0; c < NCH; c++) begin
			md = qia_mode_type'(s.mode[c]);
			// fill-based bids
			bid[c*6+QIA_SRC_RX] = {s.rx_cnt[c][3:0] - 4'h1, s.rxm[c][s.rx_rd[c]][8],
				2'b01, 3'(c)};
			act[c*6+QIA_SRC_RX] = s.rx_cnt[c] != 5'h0;
			bid[c*6+QIA_SRC_TX] = {1'b0, 4'(5'(DEPTH - 1) - s.tx_cnt[c]), 2'b00, 3'(c)};
			act[c*6+QIA_SRC_TX] = s.tx_cnt[c] != 5'(DEPTH);
			// programmed high bits rank the rest
			bid[c*6+QIA_SRC_BRK] = {md.prog, 1'b0, QIA_TY_BRK, 3'(c)};
			bid[c*6+QIA_SRC_COS] = {md.prog, 1'b0, QIA_TY_COS, 3'(c)};
			bid[c*6+QIA_SRC_FLOW] = {md.prog, 1'b0, QIA_TY_FLOW, 3'(c)};
			bid[c*6+QIA_SRC_ADDR] = {md.prog, 1'b0, QIA_TY_ADDR, 3'(c)};
			act[c*6+QIA_SRC_BRK] = s.sticky[c][QIA_ST_BRK];
			act[c*6+QIA_SRC_COS] = s.sticky[c][QIA_ST_COS];
			act[c*6+QIA_SRC_FLOW] = s.sticky[c][QIA_ST_XON] || s.sticky[c][QIA_ST_XOFF];
			act[c*6+QIA_SRC_ADDR] = s.sticky[c][QIA_ST_ADDR];
		end

		// bit-serial arbitration, highest bid survives
		if (s.arb_cnt == 5'h0) begin
			n.snap = bid;
			n.cand = act & s.mask[NS-1:0];
		end else if (s.arb_cnt <= 5'(QIA_BID_W)) begin
			for (int i = 0; i < NS; i++)
				col[i] = s.cand[i] && s.snap[i][QIA_BID_W - int'(s.arb_cnt)];
			// channel bits take part last, so d beats a on a tie
			if (col != '0)
				n.cand = col;
		end
		if (s.arb_cnt == 5'(QIA_ARB_LEN - 1)) begin
			for (int i = 0; i < NS; i++)
				if (s.cand[i])
					win = win | s.snap[i];
			n.res_bid = win;
			n.res_ok = (s.cand != '0) && (win[9:3] > s.ctrl[6:0]);
			n.irq_n = !n.res_ok;
			n.arb_cnt = 5'h0;
		end else begin
			n.arb_cnt = s.arb_cnt + 5'h1;
		end

		// register reads, data sampled in the wait cycle
		if (req && s.waitrq) begin
			n.peek_ok = 1'b0;
			if (avs_address_i[5:4] == QIA_CH_BLK) begin
				case (avs_address_i[1:0])
					QIA_SUB_MODE: rv = {24'h0, s.mode[ch]};
					QIA_SUB_CHR:  rv = {8'h0, s.own[ch], s.xoff[ch], s.xon[ch]};
					QIA_SUB_DATA: begin
						rv = {23'h0, s.rxm[ch][s.rx_rd[ch]]};
						n.peek_ok = s.rx_cnt[ch] != 5'h0;
					end
					// irq_status_reg low byte, extended_irq_status next
					QIA_SUB_STAT: rv = {21'h0, s.sticky[ch][4:2], 4'h0,
						s.sticky[ch][QIA_ST_COS], s.sticky[ch][QIA_ST_BRK],
						s.rx_cnt[ch] != 5'h0, s.tx_cnt[ch] != 5'(DEPTH)};
					default: rv = '0;
				endcase
			end else begin
				case (avs_address_i)
					QIA_OFS_CTRL: rv = {24'h0, s.ctrl};
					QIA_OFS_MASK: rv = {8'h0, s.mask};
					QIA_OFS_CAPT: rv = {22'h0, s.capt};
					QIA_OFS_VBAS: rv = {24'h0, s.vbase};
					// views follow the capture context
					QIA_OFS_GCNT: rv = {27'h0, (qia_type_of(s.capt) == QIA_TY_TX) ?
						s.tx_cnt[gch] : s.rx_cnt[gch]};
					QIA_OFS_GCHN: rv = {29'h0, s.capt[2:0]};
					QIA_OFS_GTYP: rv = {29'h0, qia_type_of(s.capt)};
					QIA_OFS_GRX: begin
						rv = {23'h0, s.rxm[gch][s.rx_rd[gch]]};
						n.peek_ok = s.rx_cnt[gch] != 5'h0;
					end
					default: rv = '0; // unmapped reads zero
				endcase
			end
			n.rdata = rv;
		end

		// register writes and read side effects at the completing edge
		if (avs_address_i[5:4] == QIA_CH_BLK) begin
			if (wr) begin
				case (avs_address_i[1:0])
					QIA_SUB_MODE: n.mode[ch] = avs_writedata_i[7:0];
					QIA_SUB_CHR: begin
						n.xon[ch] = avs_writedata_i[7:0];
						n.xoff[ch] = avs_writedata_i[15:8];
						n.own[ch] = avs_writedata_i[23:16];
					end
					QIA_SUB_DATA: tx_push[ch] = 1'b1;
					QIA_SUB_STAT: clr = avs_writedata_i[4:0]; // write one to clear
					default: ;
				endcase
			end
			if (rd && avs_address_i[1:0] == QIA_SUB_DATA && s.peek_ok)
				rx_pop[ch] = 1'b1;
		end else if (wr) begin
			case (avs_address_i)
				QIA_OFS_CTRL: n.ctrl = avs_writedata_i[7:0];
				QIA_OFS_MASK: n.mask = avs_writedata_i[23:0];
				QIA_OFS_VBAS: n.vbase = avs_writedata_i[7:0];
				QIA_OFS_GTX:  tx_push[gch] = 1'b1;
				QIA_OFS_CMD: begin
					case (avs_writedata_i[7:0])
						QIA_CMD_GWRITE: begin
							for (int c = 0; c < NCH; c++) begin
								n.xon[c] = avs_writedata_i[15:8];
								n.xoff[c] = avs_writedata_i[15:8];
								n.own[c] = avs_writedata_i[15:8];
							end
						end
						QIA_CMD_GLOAD: begin
							for (int c = 0; c < NCH; c++) begin
								n.xon[c] = QIA_XON_STD;
								n.xoff[c] = QIA_XOFF_STD;
							end
						end
						QIA_CMD_UPDATE: cap = 1'b1;
						default: ;
					endcase
				end
				default: ; // unmapped writes ignored
			endcase
		end else if (rd && avs_address_i == QIA_OFS_GRX && s.peek_ok) begin
			rx_pop[gch] = 1'b1;
		end

		// capture on the falling edge of acknowledge or by command
		n.ack_d = !irq_acknowledge_n_i;
		if (!irq_acknowledge_n_i && !s.ack_d)
			cap = 1'b1;
		if (cap)
			n.capt = s.res_ok ? s.res_bid : 10'h0;
		n.vec = n.ctrl[7] ? {n.vbase[7:5], qia_type_of(n.capt), n.capt[1:0]} : n.vbase;

		// per channel queues, status and line outputs
		for (int c = 0; c < NCH; c++) begin
			set = '0;
			set[QIA_ST_BRK] = line_i.brk_chg[c];
			set[QIA_ST_COS] = line_i.cos[c];
			set[QIA_ST_XON] = xon_w[c];
			set[QIA_ST_XOFF] = xoff_w[c];
			set[QIA_ST_ADDR] = addr_w[c];
			// a new event outranks a clear in the same cycle
			n.sticky[c] = (s.sticky[c] & ~((c == int'(ch)) ? clr : 5'h0)) | set;
			// receive queue; a full queue drops the character
			if (push_w[c] && s.rx_cnt[c] != 5'(DEPTH)) begin
				n.rxm[c][s.rx_wr[c]] = {line_i.rx_err[c], line_i.rx_data[c]};
				n.rx_wr[c] = s.rx_wr[c] + 4'h1;
				n.rx_cnt[c] = n.rx_cnt[c] + 5'h1;
			end
			if (rx_pop[c]) begin
				n.rx_rd[c] = s.rx_rd[c] + 4'h1;
				n.rx_cnt[c] = n.rx_cnt[c] - 5'h1;
			end
			// transmit queue; writes to a full queue are lost
			if (tx_push[c] && s.tx_cnt[c] != 5'(DEPTH)) begin
				n.txm[c][s.tx_wr[c]] = tx_byte;
				n.tx_wr[c] = s.tx_wr[c] + 4'h1;
				n.tx_cnt[c] = n.tx_cnt[c] + 5'h1;
			end
			// output stage refills when empty or taken, unless paused
			if (line_i.tx_take[c] && s.line.tx_valid[c])
				n.line.tx_valid[c] = 1'b0;
			if (!n.line.tx_valid[c] && s.tx_cnt[c] != 5'h0 && !pause_w[c]) begin
				n.line.tx_valid[c] = 1'b1;
				n.line.tx_data[c] = s.txm[c][s.tx_rd[c]];
				n.tx_rd[c] = s.tx_rd[c] + 4'h1;
				n.tx_cnt[c] = n.tx_cnt[c] - 5'h1;
			end
			n.line.tx_paused[c] = pause_w[c];
			n.line.rx_enabled[c] = en_w[c];
		end
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.waitrq <= 1'b1;
			s.irq_n <= 1'b1;
			s.ctrl <= QIA_RST_CTRL;
			s.mask <= QIA_RST_MASK;
			s.vbase <= QIA_RST_VBAS;
			s.vec <= QIA_RST_VBAS;
			s.mode <= {NCH{QIA_RST_MODE}};
		end else begin
			s <= n;
		end
	end

	// outputs straight from state
	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.waitrq;
	assign irq_request_n_o = s.irq_n;
	assign irq_vector_o = s.vec;
	assign line_o = s.line;
endmodule
`default_nettype wire

// [testbench/qia_arbiter_asserts.sv]
// port checker for the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module qia_arbiter_chk
	import qia_pkg::*;
(
	input wire logic             sys_clk_i,
	input wire logic             resetn_i,
	input wire logic [5:0]       avs_address_i,
	input wire logic             avs_read_i,
	input wire logic             avs_write_i,
	input wire logic [31:0]      avs_writedata_i,
	input wire logic [31:0]      avs_readdata_o,
	input wire logic             avs_waitrequest_o,
	input wire logic             irq_acknowledge_n_i,
	input wire logic             irq_request_n_o,
	input wire logic [7:0]       irq_vector_o,
	input wire qia_line_in_type  line_i,
	input wire qia_line_out_type line_o
);
	logic [5:0] hold_cnt;  // clocks since request last moved
	logic [5:0] quiet_cnt; // clocks with every source masked
	logic       mask_zero; // mask written all zero
	logic       prev_req;  // request one clock ago
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// counters saturate so long idle stretches never wrap
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			hold_cnt  <= 6'h00;
			quiet_cnt <= 6'h00;
			mask_zero <= 1'b1;
			prev_req  <= 1'b1;
		end else begin
			prev_req  <= irq_request_n_o;
			hold_cnt  <= (irq_request_n_o != prev_req) ? 6'h01 : hold_cnt + {5'h0, ~&hold_cnt};
			quiet_cnt <= mask_zero ? quiet_cnt + {5'h0, ~&quiet_cnt} : 6'h00;
			if (avs_write_i && !avs_waitrequest_o && avs_address_i == QIA_OFS_MASK) begin
				mask_zero <= (avs_writedata_i[23:0] == 24'h0);
			end
		end
	end
	AST_REQ_HOLD: assert property (
		(irq_request_n_o != prev_req) |-> hold_cnt >= 6'd21)
		else $error("request moved between arbitration results");
	AST_MASKED: assert property (quiet_cnt >= 6'd50 |-> irq_request_n_o)
		else $error("request low with every source masked");
	AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("bus answer not after one wait state");
	AST_ACK_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("bus answer stood longer than one clock");
	AST_NO_SPUR: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
		else $error("bus answer without request");
	AST_UNMAPPED: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i inside {[6'h0a:6'h0f]} |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	AST_VEC_CAUSE: assert property ($changed(irq_vector_o) |->
		!$past(irq_acknowledge_n_i) || !$past(irq_acknowledge_n_i, 2)
		|| $past(avs_write_i) || $past(avs_write_i, 2))
		else $error("vector changed without capture or write");
	AST_CAPT_W: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i == QIA_OFS_CAPT |-> avs_readdata_o[31:10] == 22'h0)
		else $error("capture read wider than bid");
endmodule
bind qia_arbiter qia_arbiter_chk u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .irq_acknowledge_n_i(irq_acknowledge_n_i),
	.irq_request_n_o(irq_request_n_o), .irq_vector_o(irq_vector_o), .line_i(line_i),
	.line_o(line_o));
`default_nettype wire

// [testbench/qia_host_model.sv]
// host side acknowledge behaviour for the interrupt request
`timescale 1ns/1ps
`default_nettype none
module qia_host_model (
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	input  wire logic go_i,     // bench allows one acknowledge
	input  wire logic req_n_i,  // interrupt request, active low
	output logic      ack_n_o   // acknowledge, active low
);
	logic [1:0] left; // clocks of acknowledge still to hold
	// answer a pending request with a three clock acknowledge
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ack_n_o <= 1'b1;
			left    <= 2'h0;
		end else if (left != 2'h0) begin
			left <= left - 2'h1;
			if (left == 2'h1) begin
				ack_n_o <= 1'b1;
			end
		end else if (go_i && !req_n_i && ack_n_o) begin
			ack_n_o <= 1'b0;
			left    <= 2'h3;
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_qia_arbiter.sv]
// bench for the interrupt arbiter over its avalon slave
`timescale 1ns/1ps
`default_nettype none
module tb_qia_arbiter
	import qia_pkg::*;
;
	logic             clk, rstn, rd_s, wr_s, go, ack_n, wreq, req_n;
	logic [5:0]       adr;
	logic [31:0]      wdat, rdat, r;
	logic [7:0]       vec;
	qia_line_in_type  li;
	qia_line_out_type lo;
	int               err_total, checked, cyc, i;
	qia_arbiter dut (.sys_clk_i(clk), .resetn_i(rstn), .avs_address_i(adr), .avs_read_i(rd_s),
		.avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .irq_acknowledge_n_i(ack_n), .irq_request_n_o(req_n),
		.irq_vector_o(vec), .line_i(li), .line_o(lo));
	qia_host_model host (.sys_clk_i(clk), .resetn_i(rstn), .go_i(go), .req_n_i(req_n),
		.ack_n_o(ack_n));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// timeout well above the several hundred clocks the tests take
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			$display("CHECK FAILED %0t timeout", $time);
			wrap_up();
		end
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until the edge that sees waitrequest low
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		adr  <= a;
		wdat <= d;
		wr_s <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		adr  <= a;
		rd_s <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		d = rdat;
		rd_s <= 1'b0;
	endtask
	task automatic rx(input int c, input logic [7:0] d, input logic ab);
		@(posedge clk);
		li.rx_valid[c]    <= 1'b1;
		li.rx_data[c]     <= d;
		li.rx_addr_bit[c] <= ab;
		@(posedge clk);
		li.rx_valid[c] <= 1'b0;
	endtask
	// bounded wait, a result lands within 44 clocks
	task automatic req_is(input logic e);
		for (int n = 0; n < 60 && req_n !== e; n++) @(posedge clk);
		cmp({31'h0, req_n}, {31'h0, e});
	endtask
	task automatic capt(output logic [31:0] d);
		wr(QIA_OFS_CMD, {24'h0, QIA_CMD_UPDATE});
		rd(QIA_OFS_CAPT, d);
	endtask
	initial begin
		{rstn, rd_s, wr_s, go, adr, wdat, li, cyc, err_total, checked} = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rd(QIA_OFS_CTRL, r); cmp(r, {24'h0, QIA_RST_CTRL});
		rd(QIA_OFS_MASK, r); cmp(r, {8'h0, QIA_RST_MASK});
		rd(QIA_OFS_VBAS, r); cmp(r, {24'h0, QIA_RST_VBAS});
		wr(6'h0c, 32'hff); rd(6'h0c, r); cmp(r, 32'h0);
		$display("test reset done");
		wr(QIA_OFS_CMD, {16'h0, 8'h41, QIA_CMD_GWRITE});
		for (i = 0; i < 4; i++) begin
			rd(6'(6'h11 + 4 * i), r); cmp(r, 32'h414141);
		end
		wr(QIA_OFS_CMD, {24'h0, QIA_CMD_GLOAD});
		for (i = 0; i < 4; i++) begin
			rd(6'(6'h11 + 4 * i), r); cmp(r, {8'h0, 8'h41, QIA_XOFF_STD, QIA_XON_STD});
		end
		$display("test gang done");
		rx(2, 8'h55, 1'b0);
		repeat (50) @(posedge clk);
		cmp({31'h0, req_n}, 32'h1);
		capt(r); cmp(r, 32'h0);
		wr(QIA_OFS_MASK, 32'h1000);
		req_is(1'b0);
		capt(r); cmp(r, 32'h00a);
		rd(QIA_OFS_GCHN, r); cmp(r, 32'h2);
		rd(QIA_OFS_GTYP, r); cmp(r, {29'h0, QIA_TY_RX});
		rd(QIA_OFS_GRX, r); cmp(r, 32'h055);
		req_is(1'b1);
		rx(2, 8'h66, 1'b0);
		wr(QIA_OFS_CTRL, 32'h1);
		repeat (50) @(posedge clk);
		cmp({31'h0, req_n}, 32'h1);
		rx(2, 8'h67, 1'b0);
		repeat (50) @(posedge clk);
		cmp({31'h0, req_n}, 32'h0);
		capt(r); cmp(r, 32'h04a);
		$display("test arbitration done");
		rx(3, 8'h33, 1'b0);
		rx(3, 8'h34, 1'b0);
		wr(QIA_OFS_MASK, 32'h41000);
		wr(QIA_OFS_CTRL, 32'h80);
		repeat (50) @(posedge clk);
		go <= 1'b1;
		for (i = 0; i < 60 && ack_n !== 1'b0; i++) @(posedge clk);
		go <= 1'b0;
		repeat (5) @(posedge clk);
		rd(QIA_OFS_CAPT, r); cmp(r, 32'h04b);
		cmp({24'h0, vec}, {24'h0, 3'h0, QIA_TY_RX, 2'h3});
		rd(QIA_OFS_GRX, r); cmp(r, 32'h033);
		$display("test acknowledge done");
		wr(6'h14, 32'h09);
		rx(1, QIA_XOFF_STD, 1'b0);
		repeat (2) @(posedge clk);
		cmp({31'h0, lo.tx_paused[1]}, 32'h1);
		rd(6'h17, r); cmp(r, 32'h201);
		wr(6'h16, 32'h5a);
		repeat (2) @(posedge clk);
		cmp({23'h0, lo.tx_valid[1], lo.tx_data[1]}, 32'h0);
		wr(6'h14, 32'h01);
		rx(1, QIA_XON_STD, 1'b0);
		repeat (2) @(posedge clk);
		cmp({31'h0, lo.tx_paused[1]}, 32'h0);
		cmp({23'h0, lo.tx_valid[1], lo.tx_data[1]}, 32'h15a);
		rd(6'h17, r); cmp(r, 32'h303);
		$display("test flow done");
		// doze needs parity-marked addresses: by value a foreign address looks like data
		wr(6'h10, 32'h16);
		repeat (2) @(posedge clk);
		cmp({31'h0, lo.rx_enabled[0]}, 32'h0);
		rx(0, 8'h41, 1'b1);
		repeat (2) @(posedge clk);
		cmp({31'h0, lo.rx_enabled[0]}, 32'h1);
		rx(0, 8'h42, 1'b1);
		repeat (2) @(posedge clk);
		cmp({31'h0, lo.rx_enabled[0]}, 32'h0);
		wr(6'h10, 32'h06);
		rx(0, 8'h41, 1'b0);
		repeat (2) @(posedge clk);
		cmp({31'h0, lo.rx_enabled[0]}, 32'h1);
		$display("test multidrop done");
		wr(QIA_OFS_MASK, 32'h2);
		repeat (50) @(posedge clk);
		capt(r); cmp(r, 32'h1e0);
		rd(QIA_OFS_GTYP, r); cmp(r, {29'h0, QIA_TY_TX});
		cmp({24'h0, vec}, 32'h0);
		wr(QIA_OFS_GTX, 32'h77);
		wr(QIA_OFS_GTX, 32'h78);
		rd(QIA_OFS_GCNT, r); cmp(r, 32'h1);
		cmp({23'h0, lo.tx_valid[0], lo.tx_data[0]}, 32'h177);
		$display("test transmit done");
		wrap_up();
	end
endmodule
`default_nettype wire
